// File: hw/flash_safety_timer.sv
/*
 Flash pulse safety timer: counts ticks up to the programmed limit.
 Assumes run comes from the control logic on the same clock.
*/
`timescale 1ns/100ps
module flash_safety_timer #(
  parameter int TICK_CYC = led_ctrl_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [7:0] limit,
  output logic timeout
);
  logic [31:0] tick_reg;
  logic [7:0] ticks_reg;

  // Count while running; timeout pulses for one cycle each time the tick count reaches the limit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_reg <= 32'h0;
      ticks_reg <= 8'h00;
      timeout <= 1'b0;
    end else if (!run) begin
      tick_reg <= 32'h0;
      ticks_reg <= 8'h00;
      timeout <= 1'b0;
    end else if (tick_reg == 32'(TICK_CYC - 1)) begin
      tick_reg <= 32'h0;
      timeout <= (ticks_reg == limit);
      ticks_reg <= ticks_reg + 8'h01;
    end else begin
      tick_reg <= tick_reg + 32'h1;
      timeout <= 1'b0;
    end
  end
endmodule : flash_safety_timer

// File: hw/led_ctrl_pkg.sv
/*
 Constants shared by the LED driver control logic: register map, field
 positions, reset values and timing counts.
 Assumes a 200 MHz clock and a simple strobed register port.
*/
package led_ctrl_pkg;
  // Register indices (byte address equals the index on this port)
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_TORCH = 4'h1;
  localparam logic [3:0] ADDR_FLASH = 4'h2;
  localparam logic [3:0] ADDR_TIMER = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;

  // Mode register layout
  localparam int MODE_LSB = 0;
  localparam int OV_LSB = 2;
  localparam int VMODE_BIT = 4;
  localparam int STT_BIT = 5;
  localparam int SFT_BIT = 6;

  // Operating mode field values
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_TORCH = 2'h1;
  localparam logic [1:0] MODE_FLASH = 2'h2;
  localparam logic [1:0] MODE_VOLT = 2'h3;
  localparam logic [1:0] OV_BYPASS = 2'h3;

  // Status and interrupt bit positions
  localparam int ST_LED_FAULT = 0;
  localparam int ST_THERMAL = 1;
  localparam int ST_TIMEOUT = 2;
  localparam int ST_UVLO = 3;
  localparam int IRQ_W = 3;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [2:0] LEVEL_RST = 3'h0;
  localparam logic [7:0] TIMER_RST = 8'h0F;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

  // Timing: safety timer tick and soft-start step
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 4000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int SS_STEP_NS = 40;
  localparam int SS_STEP_CYC = (SS_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_W = 6;
endpackage : led_ctrl_pkg

// File: hw/led_driver_mode_fault_control.sv
/*
 Mode, fault and strobe control of a flash LED boost driver.
 Assumes synchronous pin inputs, analog comparators on the same clock,
 and a strobed register port with read data one cycle later.
*/
// Functional notes
// - Mode field zero without voltage command or pin forces shutdown
// - Shutdown stops switching, LED pin floats
// - Shutdown, select not 11: both switches off
// - Shutdown, select 11: rectifier held on
// - Short LED limits current, sets fault
// - Open LED clamps output, sets fault
// - Over-temperature disables stages, clears mode
// - Thermal flag held until read
// - Undervoltage blocks both power switches
// - Enable starts switching with ramped reference
// - Voltage mode by command or pin
// - Strobe selects level without latency (with STT the code adds one clock through flash_run_reg)
// - Safety timer bounds flash pulse
// - Serial link limited to 400 kbps
// - Host sets mode, levels, voltage, timer
// - Torch mode ignores strobe, timer off
// - Voltage mode field regulates, sink disconnected
// - Strobe low torch, high flash
`timescale 1ns/100ps
module led_driver_mode_fault_control #(
  parameter int TICK_CYC = led_ctrl_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic flash_strobe,
  input wire logic hw_voltage_mode_input,
  input wire logic led_short_det,
  input wire logic led_open_det,
  input wire logic over_temp_det,
  input wire logic uvlo_det,
  output logic power_switch_on,
  output logic rectifier_on,
  output logic converter_enable,
  output logic voltage_mode,
  output logic led_sink_enable,
  output logic led_pin_hiz,
  output logic output_clamp_en,
  output logic current_limit_en,
  output logic [2:0] led_level,
  output logic [led_ctrl_pkg::REF_W-1:0] ref_level,
  output logic irq
);
  logic [1:0] mode_reg;
  logic [1:0] output_voltage_select;
  logic vmode_cmd_reg;
  logic stt_reg;
  logic sft_reg;
  logic [2:0] torch_level;
  logic [2:0] flash_level;
  logic [7:0] flash_safety_timer_limit;
  logic led_fault_flag;
  logic thermal_fault_flag;
  logic [led_ctrl_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [led_ctrl_pkg::IRQ_W-1:0] irq_mask_reg;
  logic strobe_d_reg;
  logic sft_d_reg;
  logic flash_run_reg;
  logic flash_expired_reg;
  logic timeout;
  logic shutdown;
  logic vm_active;
  logic flash_active;
  logic trig_rise;
  logic wr_mode;
  logic rd_status;
  logic [led_ctrl_pkg::IRQ_W-1:0] irq_events;

  // Address match helper used by both read and write decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction : hit

  // A strobe every clock is far quicker than any serial host can send
  assign wr_mode = wr_en && hit(addr, led_ctrl_pkg::ADDR_MODE);
  assign rd_status = rd_en && hit(addr, led_ctrl_pkg::ADDR_STATUS);
  assign trig_rise = (flash_strobe && !strobe_d_reg) ||
                     (sft_reg && !sft_d_reg);

  // Operating decode
  assign vm_active = (mode_reg == led_ctrl_pkg::MODE_VOLT) ||
                     vmode_cmd_reg || hw_voltage_mode_input;
  assign shutdown = (mode_reg == led_ctrl_pkg::MODE_OFF) &&
                    !vm_active;

  // Flash pulse only in flash mode; torch mode ignores strobe and SFT
  always_comb begin
    if (mode_reg != led_ctrl_pkg::MODE_FLASH) begin
      flash_active = 1'b0;
    end else if (stt_reg) begin
      flash_active = flash_run_reg;
    end else begin
      flash_active = (flash_strobe || sft_reg) && !timeout &&
                     !flash_expired_reg;
    end
  end

  // Mode register, with thermal clear and timeout clear of SFT
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= led_ctrl_pkg::MODE_RST[1:0];
      output_voltage_select <= led_ctrl_pkg::MODE_RST[3:2];
      vmode_cmd_reg <= 1'b0;
      stt_reg <= 1'b0;
      sft_reg <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_reg <= wdata[led_ctrl_pkg::MODE_LSB +: 2];
        output_voltage_select <= wdata[led_ctrl_pkg::OV_LSB +: 2];
        vmode_cmd_reg <= wdata[led_ctrl_pkg::VMODE_BIT];
        stt_reg <= wdata[led_ctrl_pkg::STT_BIT];
        sft_reg <= wdata[led_ctrl_pkg::SFT_BIT];
      end
      // Hardware clears win over a same-cycle write
      if (timeout) begin
        sft_reg <= 1'b0;
      end
      if (over_temp_det) begin
        mode_reg <= led_ctrl_pkg::MODE_OFF;
        vmode_cmd_reg <= 1'b0;
      end
    end
  end

  // Level and timer limit registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      torch_level <= led_ctrl_pkg::LEVEL_RST;
      flash_level <= led_ctrl_pkg::LEVEL_RST;
      flash_safety_timer_limit <= led_ctrl_pkg::TIMER_RST;
    end else if (wr_en) begin
      if (hit(addr, led_ctrl_pkg::ADDR_TORCH)) begin
        torch_level <= wdata[2:0];
      end
      if (hit(addr, led_ctrl_pkg::ADDR_FLASH)) begin
        flash_level <= wdata[2:0];
      end
      if (hit(addr, led_ctrl_pkg::ADDR_TIMER)) begin
        flash_safety_timer_limit <= wdata;
      end
    end
  end

  // Trigger edge detection and run latch, edge-sensitive with STT, following the trigger level without it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strobe_d_reg <= 1'b0;
      sft_d_reg <= 1'b0;
      flash_run_reg <= 1'b0;
    end else begin
      strobe_d_reg <= flash_strobe;
      sft_d_reg <= sft_reg;
      if (mode_reg != led_ctrl_pkg::MODE_FLASH || timeout) begin
        flash_run_reg <= 1'b0;
      end else if (stt_reg) begin
        // Once running, further triggers are ignored
        if (trig_rise) begin
          flash_run_reg <= 1'b1;
        end
      end else begin
        // A timed-out level pulse stays off until the trigger drops
        flash_run_reg <= (flash_strobe || sft_reg) && !flash_expired_reg;
      end
    end
  end

  // Timed-out marker for level mode; without it a held strobe would
  // restart the safety timer at once and the pulse would never end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flash_expired_reg <= 1'b0;
    end else if (mode_reg != led_ctrl_pkg::MODE_FLASH) begin
      flash_expired_reg <= 1'b0;
    end else if (timeout) begin
      flash_expired_reg <= 1'b1;
    end else if (!(flash_strobe || sft_reg)) begin
      flash_expired_reg <= 1'b0;
    end
  end

  // Fault flags: set wins over the clearing read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      led_fault_flag <= 1'b0;
      thermal_fault_flag <= 1'b0;
    end else begin
      if (led_short_det || led_open_det) begin
        led_fault_flag <= 1'b1;
      end else if (rd_status) begin
        led_fault_flag <= 1'b0;
      end
      if (over_temp_det) begin
        thermal_fault_flag <= 1'b1;
      end else if (rd_status) begin
        thermal_fault_flag <= 1'b0;
      end
    end
  end

  // Interrupt status, write one to clear, events win
  assign irq_events = {timeout, over_temp_det, led_short_det || led_open_det};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= led_ctrl_pkg::MASK_RST;
    end else begin
      if (wr_en && hit(addr, led_ctrl_pkg::ADDR_IRQ_MASK)) begin
        irq_mask_reg <= wdata[led_ctrl_pkg::IRQ_W-1:0];
      end
      if (wr_en && hit(addr, led_ctrl_pkg::ADDR_IRQ_STAT)) begin
        irq_stat_reg <= (irq_stat_reg & ~wdata[led_ctrl_pkg::IRQ_W-1:0]) |
                        irq_events;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_events;
      end
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read data, registered; unmapped reads return zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        led_ctrl_pkg::ADDR_MODE: rdata <= {1'b0, sft_reg, stt_reg,
          vmode_cmd_reg, output_voltage_select, mode_reg};
        led_ctrl_pkg::ADDR_TORCH: rdata <= {5'h00, torch_level};
        led_ctrl_pkg::ADDR_FLASH: rdata <= {5'h00, flash_level};
        led_ctrl_pkg::ADDR_TIMER: rdata <= flash_safety_timer_limit;
        led_ctrl_pkg::ADDR_STATUS: rdata <= {4'h0, uvlo_det, flash_run_reg,
          thermal_fault_flag, led_fault_flag};
        led_ctrl_pkg::ADDR_IRQ_STAT: rdata <= {5'h00, irq_stat_reg};
        led_ctrl_pkg::ADDR_IRQ_MASK: rdata <= {5'h00, irq_mask_reg};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Power stage drive; thermal disables the converter, undervoltage blocks both switches
  always_comb begin
    converter_enable = !shutdown && !over_temp_det;
    voltage_mode = vm_active && converter_enable;
    // Switch gates shown as enables to the analog PWM stage
    power_switch_on = converter_enable && !uvlo_det;
    if (uvlo_det) begin
      rectifier_on = 1'b0;
    end else if (shutdown) begin
      rectifier_on = (output_voltage_select ==
                      led_ctrl_pkg::OV_BYPASS);
    end else begin
      rectifier_on = converter_enable;
    end
    // Sink off in shutdown, thermal trip, or pure voltage mode
    led_sink_enable = converter_enable &&
                      (mode_reg == led_ctrl_pkg::MODE_TORCH ||
                       mode_reg == led_ctrl_pkg::MODE_FLASH);
    led_pin_hiz = !led_sink_enable;
    current_limit_en = led_short_det && led_sink_enable;
    output_clamp_en = led_open_det && converter_enable;
    // Combinational select, so a level strobe acts with no added latency; with STT the level follows flash_run_reg, one clock later
    led_level = flash_active ? flash_level : torch_level;
  end

  // Soft start ramps while the converter is enabled
  soft_start_ramp u_ramp (
    .clk(clk),
    .resetn(resetn),
    .enable(converter_enable),
    .ref_level(ref_level)
  );

  // Timer runs only during a flash pulse in flash mode
  flash_safety_timer #(.TICK_CYC(TICK_CYC)) u_timer (
    .clk(clk),
    .resetn(resetn),
    .run(flash_run_reg),
    .limit(flash_safety_timer_limit),
    .timeout(timeout)
  );

  a_mode_clear: assert property (@(posedge clk) disable iff (!resetn)
    over_temp_det |=> mode_reg == led_ctrl_pkg::MODE_OFF)
    else $error("mode not cleared by thermal trip");
  a_thermal_hold: assert property (@(posedge clk) disable iff (!resetn)
    thermal_fault_flag && !rd_status |=> thermal_fault_flag)
    else $error("thermal flag lost without read");
  a_thermal_read: assert property (@(posedge clk) disable iff (!resetn)
    rd_status && !over_temp_det |=> !thermal_fault_flag)
    else $error("thermal flag not cleared by read");
  a_uvlo_block: assert property (@(posedge clk) disable iff (!resetn)
    uvlo_det |-> !power_switch_on && !rectifier_on)
    else $error("switch on during undervoltage");
  a_off_bypass: assert property (@(posedge clk) disable iff (!resetn)
    shutdown && !uvlo_det |-> !power_switch_on && led_pin_hiz &&
    rectifier_on == (output_voltage_select == 2'h3))
    else $error("wrong shutdown switch state");
  a_fault_set: assert property (@(posedge clk) disable iff (!resetn)
    led_short_det || led_open_det |=> led_fault_flag)
    else $error("led fault flag not set");
  a_torch_only: assert property (@(posedge clk) disable iff (!resetn)
    mode_reg == led_ctrl_pkg::MODE_TORCH |-> led_level == torch_level ##1
    !flash_run_reg)
    else $error("torch mode left torch level");
  a_strobe_level: assert property (@(posedge clk) disable iff (!resetn)
    mode_reg == led_ctrl_pkg::MODE_FLASH && !stt_reg && flash_strobe &&
    !timeout && !flash_expired_reg |-> led_level == flash_level)
    else $error("strobe did not select flash level");
  a_vm_sink: assert property (@(posedge clk) disable iff (!resetn)
    mode_reg == led_ctrl_pkg::MODE_VOLT && !over_temp_det |->
    voltage_mode && !led_sink_enable)
    else $error("voltage mode sink not off");
  a_pin_vmode: assert property (@(posedge clk) disable iff (!resetn)
    hw_voltage_mode_input && !over_temp_det |-> voltage_mode)
    else $error("pin did not enter voltage mode");
  a_shutdown_off: assert property (@(posedge clk) disable iff (!resetn)
    mode_reg == led_ctrl_pkg::MODE_OFF && !vmode_cmd_reg &&
    !hw_voltage_mode_input |-> !converter_enable && !power_switch_on &&
    led_pin_hiz)
    else $error("off mode left the stage running");
  a_thermal_off: assert property (@(posedge clk) disable iff (!resetn)
    over_temp_det |-> !converter_enable && !led_sink_enable &&
    !power_switch_on)
    else $error("stage running during thermal trip");
  a_timeout_stop: assert property (@(posedge clk) disable iff (!resetn)
    timeout |=> !flash_run_reg)
    else $error("flash pulse ran past timeout");
  a_level_expire: assert property (@(posedge clk) disable iff (!resetn)
    mode_reg == led_ctrl_pkg::MODE_FLASH && !stt_reg && timeout ##1
    mode_reg == led_ctrl_pkg::MODE_FLASH && !stt_reg && flash_strobe |->
    led_level == torch_level)
    else $error("held strobe restarted a timed-out pulse");
  a_ramp_zero: assert property (@(posedge clk) disable iff (!resetn)
    !converter_enable |=> ref_level == '0)
    else $error("reference not restarted from zero");
endmodule : led_driver_mode_fault_control

// File: hw/soft_start_ramp.sv
/*
 Internal reference ramp used at converter enable to limit inrush.
 Assumes enable is a level from the control logic on the same clock.
*/
`timescale 1ns/100ps
module soft_start_ramp (
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable,
  output logic [led_ctrl_pkg::REF_W-1:0] ref_level
);
  logic [7:0] step_cnt_reg;
  localparam logic [7:0] STEP_LAST = 8'(led_ctrl_pkg::SS_STEP_CYC - 1);
  localparam logic [led_ctrl_pkg::REF_W-1:0] REF_MAX = '1;

  // Reference climbs one step per interval, drops at once when disabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      step_cnt_reg <= 8'h00;
      ref_level <= '0;
    end else if (!enable) begin
      step_cnt_reg <= 8'h00;
      ref_level <= '0;
    end else if (step_cnt_reg == STEP_LAST) begin
      step_cnt_reg <= 8'h00;
      if (ref_level != REF_MAX) begin
        ref_level <= ref_level + 1'b1;
      end
    end else begin
      step_cnt_reg <= step_cnt_reg + 8'h01;
    end
  end
endmodule : soft_start_ramp

// File: tb/host_model.sv
/*
 Host side of the register port: one-cycle write and read strobes.
 Assumes the block answers a read in the cycle after the strobe.
*/
`timescale 1ns/100ps
module host_model (
  input wire logic clk,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr_en,
  output logic rd_en,
  input wire logic [7:0] rdata
);
  // Idle bus from time zero
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  // One strobe cycle; released lines show the inverse, not stale data
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    #1;
  endtask : write_reg

  // Read data stand only in the cycle after the strobe
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask : read_reg
endmodule : host_model

// File: tb/tb_top.sv
/*
 Self-checking bench of the LED driver control block.
 Assumes the host model above and a short safety-timer tick.
*/
`timescale 1ns/100ps
module tb_top;
  logic clk, resetn, flash_strobe, hw_voltage_mode_input;
  logic led_short_det, led_open_det, over_temp_det, uvlo_det;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rd;
  logic wr_en, rd_en, power_switch_on, rectifier_on, converter_enable;
  logic voltage_mode, led_sink_enable, led_pin_hiz, output_clamp_en;
  logic current_limit_en, irq;
  logic [2:0] led_level, tl, fl;
  logic [led_ctrl_pkg::REF_W-1:0] ref_level;
  logic [31:0] seed;
  int n_mismatch, checks_done, cnt;
  int model_reg[0:6];
  localparam int TICK = 4;

  host_model i_host (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata));
  led_driver_mode_fault_control #(.TICK_CYC(TICK)) i_dut (.clk(clk),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .flash_strobe(flash_strobe),
    .hw_voltage_mode_input(hw_voltage_mode_input),
    .led_short_det(led_short_det), .led_open_det(led_open_det),
    .over_temp_det(over_temp_det), .uvlo_det(uvlo_det),
    .power_switch_on(power_switch_on), .rectifier_on(rectifier_on),
    .converter_enable(converter_enable), .voltage_mode(voltage_mode),
    .led_sink_enable(led_sink_enable), .led_pin_hiz(led_pin_hiz),
    .output_clamp_en(output_clamp_en), .current_limit_en(current_limit_en),
    .led_level(led_level), .ref_level(ref_level), .irq(irq));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic print_verdict();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check

  // Writes keep the bench's register image in step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_host.write_reg(a, d);
    if (a == 4'h1 || a == 4'h2 || a == 4'h6) model_reg[a] = d & 8'h07;
    else if (a == 4'h3) model_reg[a] = d;
    else if (a == 4'h0) model_reg[a] = d & 8'h7F;
  endtask : wr

  task automatic rd_exp(input logic [3:0] a, input logic [7:0] exp);
    i_host.read_reg(a, rd);
    check(rd, exp);
  endtask : rd_exp

  // Converter, voltage-mode and sink levels as one small vector
  task automatic outs(input logic [2:0] exp);
    check({5'h00, converter_enable, voltage_mode, led_sink_enable}, exp);
  endtask : outs

  // Bounded wait for the interrupt; a spent bound ends the run at once
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 60) begin
      $display("unexpected at %0t: interrupt never came", $time);
      n_mismatch++;
      print_verdict();
    end
  endtask : wait_irq

  task automatic pin(input int which, input logic v);
    @(posedge clk);
    case (which)
      0: flash_strobe <= v;
      1: hw_voltage_mode_input <= v;
      2: led_short_det <= v;
      3: led_open_det <= v;
      4: over_temp_det <= v;
      default: uvlo_det <= v;
    endcase
    #1;
  endtask : pin

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    n_mismatch = 0;
    checks_done = 0;
    seed = 32'h53CD7D4E;
    resetn = 1'b0;
    {flash_strobe, hw_voltage_mode_input, led_short_det} = 3'h0;
    {led_open_det, over_temp_det, uvlo_det} = 3'h0;
    model_reg = '{0, 0, 0, 32'h0F, 0, 0, 0};
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    // Reset values, then shutdown with both switches off
    for (int a = 0; a < 7; a++) rd_exp(a[3:0], model_reg[a][7:0]);
    check({7'h00, led_pin_hiz}, 8'h01);
    check({6'h00, power_switch_on, rectifier_on}, 8'h00);
    outs(3'b000);
    // Rectifier bypass in shutdown; undervoltage still blocks it
    wr(4'h0, 8'h0C);
    check({6'h00, power_switch_on, rectifier_on}, 8'h01);
    pin(5, 1'b1);
    check({6'h00, power_switch_on, rectifier_on}, 8'h00);
    rd_exp(4'h4, 8'h08);
    pin(5, 1'b0);
    // Random levels, kept distinct so a wrong pick shows
    seed = xorshift(seed);
    tl = seed[2:0];
    fl = tl ^ {seed[4:3], 1'b1};
    wr(4'h1, {5'h00, tl});
    wr(4'h2, {5'h00, fl});
    wr(4'h3, 8'h02);
    for (int a = 0; a < 4; a++) rd_exp(a[3:0], model_reg[a][7:0]);
    // Torch ignores the strobe; reference ramps after enable
    wr(4'h0, 8'h01);
    outs(3'b101);
    check({7'h00, led_pin_hiz}, 8'h00);
    pin(0, 1'b1);
    check({5'h00, led_level}, {5'h00, tl});
    pin(0, 1'b0);
    repeat (40) @(posedge clk);
    #1;
    check({7'h00, ref_level >= 3}, 8'h01);
    // Voltage mode by pin, then by mode field value 3
    pin(1, 1'b1);
    outs(3'b111);
    wr(4'h0, 8'h00);
    outs(3'b110);
    pin(1, 1'b0);
    wr(4'h0, 8'h03);
    outs(3'b110);
    // Level strobe: a held strobe falls back to torch at the timeout
    wr(4'h6, 8'h04);
    wr(4'h0, 8'h02);
    check({5'h00, led_level}, {5'h00, tl});
    pin(0, 1'b1);
    check({5'h00, led_level}, {5'h00, fl});
    wait_irq(cnt);
    check({7'h00, cnt >= 3 * TICK}, 8'h01);
    check({5'h00, led_level}, {5'h00, tl});
    pin(0, 1'b0);
    rd_exp(4'h5, 8'h04);
    wr(4'h6, 8'h00);
    check({7'h00, irq}, 8'h00);
    wr(4'h6, 8'h04);
    check({7'h00, irq}, 8'h01);
    wr(4'h5, 8'h04);
    check({7'h00, irq}, 8'h00);
    // Edge mode: one short strobe edge gives a whole pulse
    wr(4'h0, 8'h22);
    pin(0, 1'b1);
    pin(0, 1'b0);
    check({5'h00, led_level}, {5'h00, fl});
    wait_irq(cnt);
    check({7'h00, cnt >= 3 * TICK}, 8'h01);
    check({5'h00, led_level}, {5'h00, tl});
    // Software trigger; the timeout clears its bit
    wr(4'h5, 8'h04);
    wr(4'h0, 8'h62);
    wait_irq(cnt);
    check({5'h00, led_level}, {5'h00, tl});
    model_reg[0] = model_reg[0] & 8'hBF;
    rd_exp(4'h0, model_reg[0][7:0]);
    wr(4'h5, 8'h04);
    // Short and open LED faults, flag cleared by a read
    wr(4'h0, 8'h01);
    pin(2, 1'b1);
    check({7'h00, current_limit_en}, 8'h01);
    pin(2, 1'b0);
    rd_exp(4'h4, 8'h01);
    rd_exp(4'h4, 8'h00);
    pin(3, 1'b1);
    check({7'h00, output_clamp_en}, 8'h01);
    pin(3, 1'b0);
    rd_exp(4'h4, 8'h01);
    // Thermal trip clears the mode field; flag held until read
    pin(4, 1'b1);
    pin(4, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    outs(3'b000);
    model_reg[0] = model_reg[0] & 8'hEC;
    rd_exp(4'h0, model_reg[0][7:0]);
    rd_exp(4'h4, 8'h02);
    rd_exp(4'h4, 8'h00);
    // Unmapped place reads zero and ignores writes
    wr(4'hF, 8'hA5);
    rd_exp(4'hF, 8'h00);
    print_verdict();
  end
endmodule : tb_top
